/* File: hdl/iio_pkg.sv */
// Shared constants and carrier types for the isolated I/O status and reset block
package iio_pkg;

    // Register offsets within the four-port window (low two address bits)
    localparam logic [1:0] OFS_IN0        = 2'h0;
    localparam logic [1:0] OFS_IN1        = 2'h1;
    localparam logic [1:0] OFS_IN2        = 2'h2;
    localparam logic [1:0] OFS_STATUS     = 2'h3;
    localparam logic [1:0] OFS_OUT0       = 2'h0;
    localparam logic [1:0] OFS_OUT1       = 2'h1;
    localparam logic [1:0] OFS_RELAY      = 2'h2;
    localparam logic [1:0] OFS_ENABLE     = 2'h3;

    // Status byte field positions
    localparam int         ST_IN_AVAIL_LSB = 0;
    localparam int         ST_OUT_READY_LSB = 3;
    localparam int         ST_UNUSED_LSB   = 5;

    // Reset values
    localparam logic [7:0] RST_BYTE       = 8'h00;
    localparam logic [2:0] RST_ENABLE     = 3'h0;

    // Output strobe timing
    localparam int         CLK_MHZ        = 250;
    localparam int         STROBE_DELAY_US = 104;
    localparam int         STROBE_WIDTH_US = 16;
    localparam int         STROBE_DELAY_CYC = STROBE_DELAY_US * CLK_MHZ;
    localparam int         STROBE_WIDTH_CYC = STROBE_WIDTH_US * CLK_MHZ;

    // One bus cycle as presented by the host
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } iio_bus_req_t;

    // Requests toward the reset and interrupt lines
    typedef struct packed {
        logic reset_pull;
        logic nmi_pull;
    } iio_sys_pull_t;

endpackage

/* File: hdl/iio_in_port.sv */
// One isolated input port: data latch and acknowledge handshake
`timescale 1ns/1ps
module iio_in_port (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       latch_in,
    input  wire logic [7:0] data_in,
    input  wire logic       host_read,
    output logic [7:0]      data_reg,
    output logic            ack_reg
);
    logic       latch_prev_reg;
    logic       latch_prev_next;
    logic [7:0] data_next;
    logic       ack_next;
    logic       latch_rise;

    always_comb begin
        latch_rise      = latch_in & ~latch_prev_reg;
        latch_prev_next = latch_in;
        data_next       = data_reg;
        ack_next        = ack_reg;
        if (latch_rise) begin
            data_next = data_in;
        end
        if (host_read) begin
            ack_next = 1'b0;
        end
        if (latch_rise) begin
            ack_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        latch_prev_reg <= latch_prev_next;
        data_reg       <= data_next;
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= ack_next;
        end
    end

endmodule

/* File: hdl/iio_out_strobe.sv */
// Output valid strobe sequencer for one opto output port
`timescale 1ns/1ps
module iio_out_strobe #(
    parameter int DELAY_CYC = iio_pkg::STROBE_DELAY_CYC,
    parameter int WIDTH_CYC = iio_pkg::STROBE_WIDTH_CYC,
    parameter int CNT_W     = 16
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic start,
    output logic      strobe_n_reg,
    output logic      busy_reg
);
    typedef enum logic [1:0] {
        IIO_ST_IDLE,
        IIO_ST_DELAY,
        IIO_ST_PULSE
    } iio_strobe_state_t;

    if (DELAY_CYC < 1 || WIDTH_CYC < 1 || DELAY_CYC >= (1 << CNT_W) || WIDTH_CYC >= (1 << CNT_W)) begin : g_bad
        $error("iio_out_strobe: strobe counts do not fit the counter");
    end

    localparam logic [CNT_W-1:0] DELAY_LAST = CNT_W'(DELAY_CYC - 1);
    localparam logic [CNT_W-1:0] WIDTH_LAST = CNT_W'(WIDTH_CYC - 1);

    iio_strobe_state_t state_reg;
    iio_strobe_state_t state_next;
    logic [CNT_W-1:0]  cnt_reg;
    logic [CNT_W-1:0]  cnt_next;
    logic              strobe_n_next;
    logic              busy_next;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg + CNT_W'(1);
        unique case (state_reg)
            IIO_ST_IDLE: begin
                cnt_next = '0;
            end
            IIO_ST_DELAY: begin
                if (cnt_reg == DELAY_LAST) begin
                    state_next = IIO_ST_PULSE;
                    cnt_next   = '0;
                end
            end
            IIO_ST_PULSE: begin
                if (cnt_reg == WIDTH_LAST) begin
                    state_next = IIO_ST_IDLE;
                    cnt_next   = '0;
                end
            end
        endcase
        // New byte restarts the sequence
        if (start) begin
            state_next = IIO_ST_DELAY;
            cnt_next   = '0;
        end
        strobe_n_next = (state_next != IIO_ST_PULSE);
        busy_next     = (state_next != IIO_ST_IDLE);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg    <= IIO_ST_IDLE;
            cnt_reg      <= '0;
            strobe_n_reg <= 1'b1;
            busy_reg     <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            strobe_n_reg <= strobe_n_next;
            busy_reg     <= busy_next;
        end
    end

endmodule

/* File: hdl/iio_board.sv */
// Isolated I/O board core: port decode, status byte, output latches, reset and interrupt pull
`timescale 1ns/1ps

// Summary of operation
// - Read-only status byte at base plus three
// - Bits 0-2 show input ports holding data
// - Input bit one until host reads byte
// - Bits 3-4 output readiness, 5-7 unused
// - Busy taken from strobe sequencer state
// - Read data driven only in the cycle after a read
// - Reading input port clears its acknowledge
// - Input latch keeps byte after read
// - Bus reset ends any output strobe
// - Bus reset clears all input acknowledges
// - Bus reset floats both opto latches
// - Bus reset releases all eight relays
// - Default wiring: isolated input pulls reset
// - Jumper option: isolated input pulls interrupt
// - Output ready when strobe returns inactive
// - Output enabled by bit and no disable
module iio_board #(
    parameter int STROBE_DELAY_CYC = iio_pkg::STROBE_DELAY_CYC,
    parameter int STROBE_WIDTH_CYC = iio_pkg::STROBE_WIDTH_CYC
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire logic [5:0]           base_sel,
    input  wire iio_pkg::iio_bus_req_t bus_req,
    output logic [7:0]                rdata_reg,
    output logic                      rdata_oe_reg,
    input  wire logic [2:0]           latch_in,
    input  wire logic [23:0]          in_data,
    output logic [2:0]                input_ack_n_reg,
    output logic [7:0]                opto0_data_reg,
    output logic                      opto0_oe_reg,
    output logic [7:0]                opto1_data_reg,
    output logic                      opto1_oe_reg,
    output logic                      out_strobe0_n_reg,
    output logic                      out_strobe1_n_reg,
    output logic [7:0]                relay_drive_reg,
    input  wire logic [2:0]           out_disable,
    input  wire logic                 iso_sys_in,
    input  wire logic                 nmi_jumper,
    output logic                      reset_line_o_reg,
    output logic                      reset_line_oe_reg,
    output logic                      nmi_line_o_reg,
    output logic                      nmi_line_oe_reg
);
    function automatic logic port_hit(input logic [7:0] addr, input logic [5:0] base);
        port_hit = (addr[7:2] == base);
    endfunction

    // Strobe counts must fit the 16-bit sequencer counter
    if (STROBE_DELAY_CYC < 1 || STROBE_WIDTH_CYC < 1 ||
        STROBE_DELAY_CYC > 65535 || STROBE_WIDTH_CYC > 65535) begin : g_bad_strobe
        $error("iio_board: strobe counts out of range");
    end

    logic [2:0]  ack;
    logic [23:0] in_latch;
    logic [2:0]  in_read;
    logic [1:0]  out_start;
    logic [1:0]  out_busy;
    logic [1:0]  strobe_n;

    logic        rd_hit;
    logic        wr_hit;
    logic [1:0]  sel;
    logic [7:0]  status_byte;

    logic [7:0]  rdata_next;
    logic        rdata_oe_next;
    logic [7:0]  out0_latch_reg;
    logic [7:0]  out0_latch_next;
    logic [7:0]  out1_latch_reg;
    logic [7:0]  out1_latch_next;
    logic [7:0]  relay_latch_reg;
    logic [7:0]  relay_latch_next;
    logic [2:0]  enable_reg;
    logic [2:0]  enable_next;
    logic [2:0]  port_on;

    logic [7:0]  opto0_data_next;
    logic        opto0_oe_next;
    logic [7:0]  opto1_data_next;
    logic        opto1_oe_next;
    logic [7:0]  relay_drive_next;
    logic [2:0]  input_ack_n_next;

    iio_pkg::iio_sys_pull_t pull_next;

    // Bus decode
    always_comb begin
        sel       = bus_req.addr[1:0];
        rd_hit    = bus_req.rd & port_hit(bus_req.addr, base_sel);
        wr_hit    = bus_req.wr & port_hit(bus_req.addr, base_sel);
        in_read   = '0;
        out_start = '0;
        if (rd_hit && sel != iio_pkg::OFS_STATUS) begin
            in_read[sel] = 1'b1;
        end
        if (wr_hit && sel == iio_pkg::OFS_OUT0) begin
            out_start[0] = 1'b1;
        end
        if (wr_hit && sel == iio_pkg::OFS_OUT1) begin
            out_start[1] = 1'b1;
        end
    end

    for (genvar i = 0; i < 3; i++) begin : g_in
        iio_in_port u_in (
            .core_clk  (core_clk),
            .rst_n     (rst_n),
            .latch_in  (latch_in[i]),
            .data_in   (in_data[8*i +: 8]),
            .host_read (in_read[i]),
            .data_reg  (in_latch[8*i +: 8]),
            .ack_reg   (ack[i])
        );
    end

    for (genvar j = 0; j < 2; j++) begin : g_out
        iio_out_strobe #(
            .DELAY_CYC (STROBE_DELAY_CYC),
            .WIDTH_CYC (STROBE_WIDTH_CYC)
        ) u_strobe (
            .core_clk     (core_clk),
            .rst_n        (rst_n),
            .start        (out_start[j]),
            .strobe_n_reg (strobe_n[j]),
            .busy_reg     (out_busy[j])
        );
    end

    // Status byte and read mux
    always_comb begin
        status_byte = '0;
        status_byte[iio_pkg::ST_IN_AVAIL_LSB +: 3] = ack;
        status_byte[iio_pkg::ST_OUT_READY_LSB +: 2] = ~out_busy;
        rdata_next    = iio_pkg::RST_BYTE;
        rdata_oe_next = rd_hit;
        if (rd_hit) begin
            unique case (sel)
                iio_pkg::OFS_IN0:    rdata_next = in_latch[7:0];
                iio_pkg::OFS_IN1:    rdata_next = in_latch[15:8];
                iio_pkg::OFS_IN2:    rdata_next = in_latch[23:16];
                // status port at base plus three
                iio_pkg::OFS_STATUS: rdata_next = status_byte;
            endcase
        end
    end

    // Output latches and enable port
    always_comb begin
        out0_latch_next  = out0_latch_reg;
        out1_latch_next  = out1_latch_reg;
        relay_latch_next = relay_latch_reg;
        enable_next      = enable_reg;
        if (wr_hit) begin
            unique case (sel)
                iio_pkg::OFS_OUT0:   out0_latch_next  = bus_req.wdata;
                iio_pkg::OFS_OUT1:   out1_latch_next  = bus_req.wdata;
                iio_pkg::OFS_RELAY:  relay_latch_next = bus_req.wdata;
                iio_pkg::OFS_ENABLE: enable_next      = bus_req.wdata[2:0];
            endcase
        end
        // bit set and no hardware disable
        port_on          = enable_reg & ~out_disable;
        opto0_data_next  = out0_latch_reg;
        opto0_oe_next    = port_on[0];
        opto1_data_next  = out1_latch_reg;
        opto1_oe_next    = port_on[1];
        relay_drive_next = relay_latch_reg & {8{port_on[2]}};
        input_ack_n_next = ~ack;
    end

    // Reset and interrupt line pull
    always_comb begin
        pull_next.reset_pull = iso_sys_in & ~nmi_jumper;
        pull_next.nmi_pull   = iso_sys_in & nmi_jumper;
    end

    // Read port registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_reg    <= iio_pkg::RST_BYTE;
            rdata_oe_reg <= 1'b0;
        end else begin
            rdata_reg    <= rdata_next;
            rdata_oe_reg <= rdata_oe_next;
        end
    end

    // Output latches and enable port registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            out0_latch_reg  <= iio_pkg::RST_BYTE;
            out1_latch_reg  <= iio_pkg::RST_BYTE;
            relay_latch_reg <= iio_pkg::RST_BYTE;
            enable_reg      <= iio_pkg::RST_ENABLE;
        end else begin
            out0_latch_reg  <= out0_latch_next;
            out1_latch_reg  <= out1_latch_next;
            relay_latch_reg <= relay_latch_next;
            enable_reg      <= enable_next;
        end
    end

    // Pin driver registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            relay_drive_reg   <= iio_pkg::RST_BYTE;
            opto0_data_reg    <= iio_pkg::RST_BYTE;
            opto1_data_reg    <= iio_pkg::RST_BYTE;
            opto0_oe_reg      <= 1'b0;
            opto1_oe_reg      <= 1'b0;
            input_ack_n_reg   <= 3'h7;
            out_strobe0_n_reg <= 1'b1;
            out_strobe1_n_reg <= 1'b1;
        end else begin
            relay_drive_reg   <= relay_drive_next;
            opto0_data_reg    <= opto0_data_next;
            opto1_data_reg    <= opto1_data_next;
            opto0_oe_reg      <= opto0_oe_next;
            opto1_oe_reg      <= opto1_oe_next;
            input_ack_n_reg   <= input_ack_n_next;
            out_strobe0_n_reg <= strobe_n[0];
            out_strobe1_n_reg <= strobe_n[1];
        end
    end

    // Pull keeps tracking during reset so a held request is not released
    always_ff @(posedge core_clk) begin
        reset_line_o_reg  <= 1'b0;
        reset_line_oe_reg <= pull_next.reset_pull;
        nmi_line_o_reg    <= 1'b0;
        nmi_line_oe_reg   <= pull_next.nmi_pull;
    end

endmodule

/* File: hdl/iio_board_unused_placeholder_none.sv */
// Intentionally empty compilation unit for the isolated I/O block
`timescale 1ns/1ps

/* File: test/iio_host_model.sv */
// Host bus model issuing single-byte port cycles
`timescale 1ns/1ps
module iio_host_model (
    input  wire logic             core_clk,
    output iio_pkg::iio_bus_req_t bus_req
);
    initial bus_req = '0;
    task automatic cyc(input logic rd, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{rd, !rd, a, d};
        @(posedge core_clk);
        // Released bus carries a changed pattern
        bus_req <= '{1'b0, 1'b0, ~a, ~d};
    endtask
endmodule

/* File: test/iio_board_checker.sv */
// Assertion checker for the isolated I/O status and reset block
`timescale 1ns/1ps
module iio_board_checker #(
    parameter int STROBE_DELAY_CYC = 10,
    parameter int STROBE_WIDTH_CYC = 4
) (
    input wire logic                  core_clk,
    input wire logic                  rst_n,
    input wire logic [5:0]            base_sel,
    input wire iio_pkg::iio_bus_req_t bus_req,
    input wire logic [7:0]            rdata_reg,
    input wire logic                  rdata_oe_reg,
    input wire logic [2:0]            latch_in,
    input wire logic [2:0]            input_ack_n_reg,
    input wire logic                  opto0_oe_reg,
    input wire logic                  opto1_oe_reg,
    input wire logic                  out_strobe0_n_reg,
    input wire logic                  out_strobe1_n_reg,
    input wire logic [7:0]            relay_drive_reg,
    input wire logic                  iso_sys_in,
    input wire logic                  nmi_jumper,
    input wire logic                  reset_line_oe_reg,
    input wire logic                  nmi_line_oe_reg
);
    localparam int DLO = STROBE_DELAY_CYC + 1;
    localparam int DHI = STROBE_DELAY_CYC + 3;
    logic          hit;
    assign hit = bus_req.addr[7:2] == base_sel;
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    property p_rd_drive;
        bus_req.rd && hit |=> rdata_oe_reg;
    endproperty
    a_rd_drive: assert property (p_rd_drive) else $error("read not answered");
    property p_no_drive;
        !(bus_req.rd && hit) |=> !rdata_oe_reg;
    endproperty
    a_no_drive: assert property (p_no_drive) else $error("data driven without read");
    property p_unused;
        bus_req.rd && hit && bus_req.addr[1:0] == iio_pkg::OFS_STATUS |=> rdata_reg[7:5] == 3'h0;
    endproperty
    a_unused: assert property (p_unused) else $error("unused status bits set");
    property p_rst_state;
        $rose(rst_n) |-> input_ack_n_reg == 3'h7 && relay_drive_reg == 8'h00 && !opto0_oe_reg
            && !opto1_oe_reg && out_strobe0_n_reg && out_strobe1_n_reg;
    endproperty
    a_rst_state: assert property (p_rst_state) else $error("bad state after reset");
    property p_ack_set;
        $rose(latch_in[0]) |-> ##2 !input_ack_n_reg[0];
    endproperty
    a_ack_set: assert property (p_ack_set) else $error("latch not acknowledged");
    property p_ack_clr;
        bus_req.rd && hit && bus_req.addr[1:0] == iio_pkg::OFS_IN1 && !latch_in[1] |-> ##2 input_ack_n_reg[1];
    endproperty
    a_ack_clr: assert property (p_ack_clr) else $error("read left acknowledge");
    property p_dly;
        bus_req.wr && hit && bus_req.addr[1:0] == iio_pkg::OFS_OUT1 |-> ##[DLO:DHI] $fell(out_strobe1_n_reg);
    endproperty
    a_dly: assert property (p_dly) else $error("strobe delay wrong");
    property p_width;
        $fell(out_strobe0_n_reg) |-> ##STROBE_WIDTH_CYC $rose(out_strobe0_n_reg);
    endproperty
    a_width: assert property (p_width) else $error("strobe width wrong");
    property p_pull_rst;
        iso_sys_in && !nmi_jumper |=> reset_line_oe_reg && !nmi_line_oe_reg;
    endproperty
    a_pull_rst: assert property (p_pull_rst) else $error("reset line not pulled");
    property p_pull_nmi;
        iso_sys_in && nmi_jumper |=> nmi_line_oe_reg && !reset_line_oe_reg;
    endproperty
    a_pull_nmi: assert property (p_pull_nmi) else $error("interrupt line not pulled");
endmodule

/* File: test/iio_board_tb_top.sv */
// Testbench top for the isolated I/O status and reset block
`timescale 1ns/1ps
module iio_board_tb_top;
    localparam logic [5:0] BASE = 6'h20;
    localparam logic [7:0] ST   = {BASE, iio_pkg::OFS_STATUS};
    logic                  core_clk = 1'b0;
    logic                  rst_n = 1'b0;
    logic [2:0]            latch_in = 3'h0;
    logic [23:0]           in_data = 24'h0;
    logic [2:0]            out_disable = 3'h0;
    logic                  iso_sys_in = 1'b0;
    logic                  nmi_jumper = 1'b0;
    iio_pkg::iio_bus_req_t bus_req;
    logic [7:0]            rdata_reg, opto0_data_reg, opto1_data_reg, relay_drive_reg, d;
    logic [2:0]            input_ack_n_reg;
    logic                  rdata_oe_reg, opto0_oe_reg, opto1_oe_reg, out_strobe0_n_reg, out_strobe1_n_reg;
    logic                  reset_line_oe_reg, nmi_line_oe_reg, reset_line_o_reg, nmi_line_o_reg;
    integer                n_errors = 0;
    integer                check_count = 0;
    integer                seed = 32'h9dfb5b9e;
    logic [7:0]            exp_q[$];

    always #2 core_clk = ~core_clk;

    iio_host_model u_host (.core_clk(core_clk), .bus_req(bus_req));
    iio_board #(.STROBE_DELAY_CYC(10), .STROBE_WIDTH_CYC(4)) u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .base_sel(BASE), .bus_req(bus_req),
        .rdata_reg(rdata_reg), .rdata_oe_reg(rdata_oe_reg), .latch_in(latch_in), .in_data(in_data),
        .input_ack_n_reg(input_ack_n_reg), .opto0_data_reg(opto0_data_reg), .opto0_oe_reg(opto0_oe_reg),
        .opto1_data_reg(opto1_data_reg), .opto1_oe_reg(opto1_oe_reg), .out_strobe0_n_reg(out_strobe0_n_reg),
        .out_strobe1_n_reg(out_strobe1_n_reg), .relay_drive_reg(relay_drive_reg), .out_disable(out_disable),
        .iso_sys_in(iso_sys_in), .nmi_jumper(nmi_jumper), .reset_line_o_reg(reset_line_o_reg),
        .nmi_line_o_reg(nmi_line_o_reg),
        .reset_line_oe_reg(reset_line_oe_reg), .nmi_line_oe_reg(nmi_line_oe_reg));

    task automatic conclude();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic fail(input string m);
        n_errors++;
        $display("wrong value at %0t: %s", $time, m);
    endtask
    task automatic check_rd(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) fail("read data");
    endtask
    task automatic check_out(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) fail("port level");
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.cyc(1'b1, a, 8'h00);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wait_stb(input int j, input logic v);
        int n = 0;
        while (((j == 0) ? out_strobe0_n_reg : out_strobe1_n_reg) !== v) begin
            @(posedge core_clk);
            n++;
            if (n > 200) begin
                fail("strobe timeout");
                conclude();
            end
        end
    endtask
    task automatic outs(input logic [7:0] e);
        check_out({4'h0, opto0_oe_reg, opto1_oe_reg, out_strobe0_n_reg, out_strobe1_n_reg}, e);
    endtask

    // Read answers are matched in issue order
    always @(posedge core_clk) begin
        if (rdata_oe_reg === 1'b1) begin
            if (exp_q.size() == 0) fail("unexpected read data");
            else check_rd(rdata_reg, exp_q.pop_front());
        end
    end

    initial begin
        tick(12);
        rst_n <= 1'b1;
        tick(2);
        outs(8'h03);
        check_out(relay_drive_reg, 8'h00);
        check_out({5'h0, input_ack_n_reg}, 8'h07);
        rd(ST, 8'h18);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            d = 8'($random(seed));
            in_data[8*i +: 8] <= d;
            latch_in[i] <= 1'b1;
            tick(3);
            latch_in[i] <= 1'b0;
            check_out({5'h0, input_ack_n_reg}, 8'h07 & ~(8'h01 << i));
            rd(ST, 8'h18 | (8'h01 << i));
            rd({BASE, 2'(i)}, d);
            in_data[8*i +: 8] <= ~d;
            rd(ST, 8'h18);
            rd({BASE, 2'(i)}, d);
            tick(2);
            check_out({5'h0, input_ack_n_reg}, 8'h07);
        end
        $display("test inputs done");
        u_host.cyc(1'b1, {~BASE, iio_pkg::OFS_STATUS}, 8'h00);
        u_host.cyc(1'b0, {~BASE, iio_pkg::OFS_OUT0}, 8'h5a);
        tick(20);
        outs(8'h03);
        $display("test foreign address done");
        u_host.cyc(1'b0, {BASE, iio_pkg::OFS_ENABLE}, 8'h07);
        d = 8'($random(seed));
        u_host.cyc(1'b0, {BASE, iio_pkg::OFS_OUT0}, d);
        rd(ST, 8'h10);
        wait_stb(0, 1'b0);
        check_out(opto0_data_reg, d);
        outs(8'h0d);
        wait_stb(0, 1'b1);
        rd(ST, 8'h18);
        out_disable <= 3'h1;
        tick(4);
        outs(8'h07);
        out_disable <= 3'h0;
        d = 8'($random(seed)) | 8'h01;
        u_host.cyc(1'b0, {BASE, iio_pkg::OFS_RELAY}, d);
        tick(4);
        check_out(relay_drive_reg, d);
        out_disable <= 3'h6;
        tick(4);
        check_out(relay_drive_reg, 8'h00);
        outs(8'h0b);
        out_disable <= 3'h0;
        tick(2);
        check_out(relay_drive_reg, d);
        u_host.cyc(1'b0, {BASE, iio_pkg::OFS_ENABLE}, 8'h03);
        tick(4);
        check_out(relay_drive_reg, 8'h00);
        $display("test outputs done");
        u_host.cyc(1'b0, {BASE, iio_pkg::OFS_ENABLE}, 8'h07);
        u_host.cyc(1'b0, {BASE, iio_pkg::OFS_RELAY}, 8'hff);
        latch_in[2] <= 1'b1;
        tick(2);
        latch_in[2] <= 1'b0;
        u_host.cyc(1'b0, {BASE, iio_pkg::OFS_OUT1}, 8'ha5);
        wait_stb(1, 1'b0);
        check_out(opto1_data_reg, 8'ha5);
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        outs(8'h03);
        check_out(relay_drive_reg, 8'h00);
        check_out({5'h0, input_ack_n_reg}, 8'h07);
        rd(ST, 8'h18);
        $display("test reset mid run done");
        iso_sys_in <= 1'b1;
        tick(2);
        check_out({6'h0, reset_line_oe_reg, nmi_line_oe_reg}, 8'h02);
        check_out({6'h0, reset_line_o_reg, nmi_line_o_reg}, 8'h00);
        nmi_jumper <= 1'b1;
        tick(2);
        check_out({6'h0, reset_line_oe_reg, nmi_line_oe_reg}, 8'h01);
        iso_sys_in <= 1'b0;
        tick(4);
        check_out(8'(exp_q.size()), 8'h00);
        $display("test pull lines done");
        conclude();
    end
endmodule

bind iio_board iio_board_checker #(.STROBE_DELAY_CYC(STROBE_DELAY_CYC), .STROBE_WIDTH_CYC(STROBE_WIDTH_CYC)) u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .base_sel(base_sel), .bus_req(bus_req), .rdata_reg(rdata_reg),
    .rdata_oe_reg(rdata_oe_reg), .latch_in(latch_in), .input_ack_n_reg(input_ack_n_reg),
    .opto0_oe_reg(opto0_oe_reg), .opto1_oe_reg(opto1_oe_reg), .out_strobe0_n_reg(out_strobe0_n_reg),
    .out_strobe1_n_reg(out_strobe1_n_reg), .relay_drive_reg(relay_drive_reg), .iso_sys_in(iso_sys_in),
    .nmi_jumper(nmi_jumper), .reset_line_oe_reg(reset_line_oe_reg), .nmi_line_oe_reg(nmi_line_oe_reg));
